// File: spt_pkg.sv
// Package of constants and carrier types for the PWM time-base support block
// Notes on behaviour
// - Duty equal phase gives simultaneous fall, 0%
// - Unreached duty value gives no fall, 100%
// - Four flags set on events regardless enable
// - Master flag sets only if some enable, or on a software write of 1
// - Module disable clears source flags, not master
// - Software-set flags interrupt like hardware ones
// - Two-bit field selects one of three clocks
// - Internal fast clock runs even when disabled
// - Prescaler divides selected clock by 1,2,4,8
// - Comparator rising edges trigger selected events
// - Event pin unsynchronised, triggers on rising edge
// - Independent rise/fall blanking mode fields
// - Active blanking masks selected async sources
// - Blanking disabled passes inputs unaltered
// - Rise/fall events start their blanking counters
// - Counter counts until equal blanking time
// - Blanking uncertainty at most one core clock
// - Disabled output releases pin to GPIO
// - Enabled unsteered output holds inactive level in steering modes
// - Six outputs, steering only in three modes
// - Per-output polarity bit sets active level
// - Counter from zero, period match resets it
package spt_pkg;
    localparam int SPT_OUTS = 6;
    localparam int SPT_SRCS = 4;
    localparam logic [15:0] SPT_CNT_RST = 16'h0000;
    localparam logic [15:0] SPT_CNT_MAX = 16'hffff;
    // Address map
    localparam logic [4:0] ADR_DUTY = 5'h00;
    localparam logic [4:0] ADR_PHASE = 5'h01;
    localparam logic [4:0] ADR_PERIOD = 5'h02;
    localparam logic [4:0] ADR_TIMER = 5'h03;
    localparam logic [4:0] ADR_IRQ = 5'h04;
    localparam logic [4:0] ADR_CTRL = 5'h05;
    localparam logic [4:0] ADR_CLOCK = 5'h06;
    localparam logic [4:0] ADR_BLANK = 5'h07;
    localparam logic [4:0] ADR_BLKR = 5'h08;
    localparam logic [4:0] ADR_BLKF = 5'h09;
    localparam logic [4:0] ADR_REBS = 5'h0a;
    localparam logic [4:0] ADR_FEBS = 5'h0b;
    localparam logic [4:0] ADR_OEN = 5'h0c;
    localparam logic [4:0] ADR_STR = 5'h0d;
    localparam logic [4:0] ADR_POL = 5'h0e;
    localparam logic [4:0] ADR_EVSRC = 5'h0f;
    localparam logic [4:0] ADR_MFLAG = 5'h10;
    // Field positions
    localparam int IRQ_EN_LSB = 4;
    localparam int CTRL_EN_BIT = 7;
    localparam int CLK_DIV_LSB = 4;
    localparam int BLNK_FE_LSB = 4;
    localparam int EVS_RISE_LSB = 0;
    localparam int EVS_FALL_LSB = 4;
    localparam int EVS_PER_LSB = 8;
    // Clock source encodings
    localparam logic [1:0] CSRC_FOSC = 2'h0;
    localparam logic [1:0] CSRC_HFOSC = 2'h1;
    localparam logic [1:0] CSRC_EXT = 2'h2;
    // Blanking mode encodings
    localparam logic [1:0] BLANK_OFF = 2'h0;
    localparam logic [1:0] BLANK_IMM = 2'h1;
    // Mode encodings; all but push-pull honour steering
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_COMPL = 3'h1;
    localparam logic [2:0] MODE_PUSHPULL = 3'h2;
    localparam logic [2:0] MODE_SIXSTEP = 3'h3;
    // Bundle of synchronous match events
    typedef struct packed {
        logic period;
        logic duty;
        logic phase;
        logic ovf;
    } spt_evt_type;
    // Register bus request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } spt_bus_type;
endpackage

// File: spt_top.sv
// Top of the PWM time-base support block: clocking, time base, events, blanking, outputs
`timescale 1ns/1ps
module spt_top
    import spt_pkg::*;
(
    // Clocks and reset
    input wire logic mclk,
    input wire logic srst,
    input wire logic fosc_tick,
    input wire logic hfosc_tick,
    input wire logic ext_clk_pin,
    // Register bus
    input wire spt_bus_type bus,
    output logic [15:0] rdata,
    // Asynchronous event sources
    input wire logic comparator1_synced_out,
    input wire logic comparator2_synced_out,
    input wire logic comparator3_synced_out,
    input wire logic external_event_pin,
    // Core status
    output logic sleep_osc_keep,
    output logic core_tick,
    output logic irq_out,
    // Pins
    output logic [SPT_OUTS-1:0] pwm_out,
    output logic [SPT_OUTS-1:0] pwm_oe
);
    // Software registers
    logic [15:0] duty_match_value_ff;
    logic [15:0] phase_match_value_ff;
    logic [15:0] period_match_value_ff;
    logic [15:0] timebase_counter_ff;
    logic [3:0] irq_flag_ff;              // Per-source flags
    logic [3:0] irq_en_ff;                // Per-source enables
    logic timebase_irq_master_flag_ff;
    logic timebase_irq_master_enable_ff;
    logic module_enable_bit_ff;
    logic [2:0] mode_ff;
    logic [1:0] clock_source_select_ff;
    logic [1:0] clock_divider_select_ff;
    logic [1:0] rise_blank_mode_ff;
    logic [1:0] fall_blank_mode_ff;
    logic [7:0] rise_blank_time_ff;
    logic [7:0] fall_blank_time_ff;
    logic [SPT_SRCS-1:0] rise_blank_sources_ff;
    logic [SPT_SRCS-1:0] fall_blank_sources_ff;
    logic [SPT_SRCS-1:0] rise_src_ff;     // Async rise-event sources
    logic [SPT_SRCS-1:0] fall_src_ff;
    logic [SPT_SRCS-1:0] per_src_ff;
    logic [SPT_OUTS-1:0] output_enable_reg_ff;
    logic [SPT_OUTS-1:0] output_steering_reg_ff;
    logic [SPT_OUTS-1:0] output_polarity_reg_ff;
    // Clock synchronisers and prescaler
    logic [1:0] ext_sync_ff;
    logic ext_last_ff;
    logic [2:0] div_cnt_ff;
    logic src_tick;
    logic div_hit;
    // Event state
    logic [SPT_SRCS-1:0] src_last_ff;
    logic [SPT_SRCS-1:0] edge_raw;
    logic [SPT_SRCS-1:0] blank_mask;
    logic [SPT_SRCS-1:0] edge_ok;
    logic rise_evt;
    logic fall_evt;
    logic per_evt;
    logic pwm_ff;
    logic rise_done_ff;                   // Rise already acted this period
    logic fall_done_ff;
    logic [7:0] rblk_cnt_ff;
    logic [7:0] fblk_cnt_ff;
    logic rblk_on_ff;
    logic fblk_on_ff;
    spt_evt_type evt;
    logic [3:0] sw_flag_clr;
    logic [3:0] sw_flag_set;

    // Ext pin passes two flops: other domain
    always_ff @(posedge mclk) begin
        if (srst) begin
            ext_sync_ff <= 2'h0;
            ext_last_ff <= 1'b0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[0], ext_clk_pin};
            ext_last_ff <= ext_sync_ff[1];
        end
    end

    // Source tick mux
    always_comb begin
        if (clock_source_select_ff == CSRC_HFOSC) begin
            src_tick = hfosc_tick;
        end else if (clock_source_select_ff == CSRC_EXT) begin
            src_tick = ext_sync_ff[1] & ~ext_last_ff;
        end else begin
            src_tick = fosc_tick;
        end
    end

    // Fast oscillator request holds regardless of module enable
    assign sleep_osc_keep = (clock_source_select_ff == CSRC_HFOSC);

    // Divide selected tick by 1,2,4,8
    assign div_hit = ((div_cnt_ff & ((3'h1 << clock_divider_select_ff) - 3'h1)) == 3'h0);
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt_ff <= 3'h0;
        end else if (src_tick) begin
            div_cnt_ff <= div_cnt_ff + 3'h1;
        end
    end
    assign core_tick = src_tick & div_hit & module_enable_bit_ff;

    // Edge detect of async sources; pin is not synchronised on purpose
    always_ff @(posedge mclk) begin
        if (srst) begin
            src_last_ff <= '0;
        end else begin
            src_last_ff <= {external_event_pin, comparator3_synced_out,
                            comparator2_synced_out, comparator1_synced_out};
        end
    end
    assign edge_raw = {external_event_pin, comparator3_synced_out,
                       comparator2_synced_out, comparator1_synced_out} & ~src_last_ff;

    // Masking: off mode forwards unaltered
    assign blank_mask = ((rblk_on_ff && rise_blank_mode_ff == BLANK_IMM) ? rise_blank_sources_ff : '0)
                      | ((fblk_on_ff && fall_blank_mode_ff == BLANK_IMM) ? fall_blank_sources_ff : '0);
    assign edge_ok = edge_raw & ~blank_mask;

    // Synchronous matches; counter rollover counts as overflow
    always_comb begin
        evt.period = core_tick && (timebase_counter_ff == period_match_value_ff);
        evt.phase = core_tick && (timebase_counter_ff == phase_match_value_ff);
        evt.duty = core_tick && (timebase_counter_ff == duty_match_value_ff);
        evt.ovf = core_tick && !evt.period && (timebase_counter_ff == SPT_CNT_MAX);
    end
    assign per_evt = evt.period || (|(edge_ok & per_src_ff));
    assign rise_evt = (evt.phase || (|(edge_ok & rise_src_ff))) && !rise_done_ff && !fall_done_ff;
    // Duty never reached means no fall
    assign fall_evt = (evt.duty || (|(edge_ok & fall_src_ff))) && !fall_done_ff;

    // Time base counter
    always_ff @(posedge mclk) begin
        if (srst || !module_enable_bit_ff) begin
            timebase_counter_ff <= SPT_CNT_RST;
        end else if (per_evt) begin
            timebase_counter_ff <= SPT_CNT_RST;
        end else if (core_tick) begin
            timebase_counter_ff <= timebase_counter_ff + 16'h0001;
        end
    end

    // PWM state; fall wins over a simultaneous rise
    always_ff @(posedge mclk) begin
        if (srst || !module_enable_bit_ff) begin
            pwm_ff <= 1'b0;
            rise_done_ff <= 1'b0;
            fall_done_ff <= 1'b0;
        end else if (per_evt) begin
            // Level carries over the period so 100% duty holds
            rise_done_ff <= 1'b0;
            fall_done_ff <= 1'b0;
        end else begin
            if (fall_evt) begin
                pwm_ff <= 1'b0;
                fall_done_ff <= 1'b1;
            end else if (rise_evt) begin
                pwm_ff <= 1'b1;
            end
            if (rise_evt) begin
                rise_done_ff <= 1'b1;
            end
        end
    end

    // Rising blanking counter
    always_ff @(posedge mclk) begin
        if (srst || rise_blank_mode_ff != BLANK_IMM) begin
            rblk_on_ff <= 1'b0;
            rblk_cnt_ff <= 8'h00;
        end else if (rise_evt) begin
            rblk_on_ff <= (rise_blank_time_ff != 8'h00);
            rblk_cnt_ff <= 8'h00;
        end else if (rblk_on_ff && core_tick) begin
            rblk_cnt_ff <= rblk_cnt_ff + 8'h01;
            if (rblk_cnt_ff + 8'h01 == rise_blank_time_ff) begin
                rblk_on_ff <= 1'b0;
            end
        end
    end

    // Falling blanking counter
    always_ff @(posedge mclk) begin
        if (srst || fall_blank_mode_ff != BLANK_IMM) begin
            fblk_on_ff <= 1'b0;
            fblk_cnt_ff <= 8'h00;
        end else if (fall_evt) begin
            fblk_on_ff <= (fall_blank_time_ff != 8'h00);
            fblk_cnt_ff <= 8'h00;
        end else if (fblk_on_ff && core_tick) begin
            fblk_cnt_ff <= fblk_cnt_ff + 8'h01;
            if (fblk_cnt_ff + 8'h01 == fall_blank_time_ff) begin
                fblk_on_ff <= 1'b0;
            end
        end
    end

    // Software flag strobes
    assign sw_flag_clr = (bus.wr && bus.addr == ADR_IRQ) ? ~bus.wdata[3:0] : 4'h0;
    assign sw_flag_set = (bus.wr && bus.addr == ADR_IRQ) ? bus.wdata[3:0] : 4'h0;

    // Per-source flags: set wins over clear, disable clears all
    always_ff @(posedge mclk) begin
        if (srst || !module_enable_bit_ff) begin
            irq_flag_ff <= 4'h0;
        end else begin
            irq_flag_ff <= (irq_flag_ff & ~sw_flag_clr) | sw_flag_set
                         | {evt.period, evt.duty, evt.phase, evt.ovf};
        end
    end

    // Master flag
    always_ff @(posedge mclk) begin
        if (srst) begin
            timebase_irq_master_flag_ff <= 1'b0;
        end else if (|(irq_flag_ff & irq_en_ff)) begin
            timebase_irq_master_flag_ff <= 1'b1;
        end else if (bus.wr && bus.addr == ADR_MFLAG) begin
            // Clearing sticks only once no enabled source flag is left
            timebase_irq_master_flag_ff <= bus.wdata[0];
        end
    end
    assign irq_out = timebase_irq_master_flag_ff & timebase_irq_master_enable_ff;

    // Register writes
    always_ff @(posedge mclk) begin
        if (srst) begin
            duty_match_value_ff <= 16'h0000;
            phase_match_value_ff <= 16'h0000;
            period_match_value_ff <= 16'h0000;
            irq_en_ff <= 4'h0;
            module_enable_bit_ff <= 1'b0;
            mode_ff <= MODE_SINGLE;
            timebase_irq_master_enable_ff <= 1'b0;
            clock_source_select_ff <= CSRC_FOSC;
            clock_divider_select_ff <= 2'h0;
            rise_blank_mode_ff <= BLANK_OFF;
            fall_blank_mode_ff <= BLANK_OFF;
            rise_blank_time_ff <= 8'h00;
            fall_blank_time_ff <= 8'h00;
            rise_blank_sources_ff <= '0;
            fall_blank_sources_ff <= '0;
            rise_src_ff <= '0;
            fall_src_ff <= '0;
            per_src_ff <= '0;
            output_enable_reg_ff <= '0;
            output_steering_reg_ff <= '0;
            output_polarity_reg_ff <= '0;
        end else if (bus.wr) begin
            if (bus.addr == ADR_DUTY) begin
                duty_match_value_ff <= bus.wdata;
            end else if (bus.addr == ADR_PHASE) begin
                phase_match_value_ff <= bus.wdata;
            end else if (bus.addr == ADR_PERIOD) begin
                period_match_value_ff <= bus.wdata;
            end else if (bus.addr == ADR_IRQ) begin
                irq_en_ff <= bus.wdata[IRQ_EN_LSB +: 4];
            end else if (bus.addr == ADR_CTRL) begin
                module_enable_bit_ff <= bus.wdata[CTRL_EN_BIT];
                mode_ff <= bus.wdata[2:0];
                timebase_irq_master_enable_ff <= bus.wdata[8];
            end else if (bus.addr == ADR_CLOCK) begin
                clock_source_select_ff <= bus.wdata[1:0];
                clock_divider_select_ff <= bus.wdata[CLK_DIV_LSB +: 2];
            end else if (bus.addr == ADR_BLANK) begin
                rise_blank_mode_ff <= bus.wdata[1:0];
                fall_blank_mode_ff <= bus.wdata[BLNK_FE_LSB +: 2];
            end else if (bus.addr == ADR_BLKR) begin
                rise_blank_time_ff <= bus.wdata[7:0];
            end else if (bus.addr == ADR_BLKF) begin
                fall_blank_time_ff <= bus.wdata[7:0];
            end else if (bus.addr == ADR_REBS) begin
                rise_blank_sources_ff <= bus.wdata[SPT_SRCS-1:0];
            end else if (bus.addr == ADR_FEBS) begin
                fall_blank_sources_ff <= bus.wdata[SPT_SRCS-1:0];
            end else if (bus.addr == ADR_OEN) begin
                output_enable_reg_ff <= bus.wdata[SPT_OUTS-1:0];
            end else if (bus.addr == ADR_STR) begin
                output_steering_reg_ff <= bus.wdata[SPT_OUTS-1:0];
            end else if (bus.addr == ADR_POL) begin
                output_polarity_reg_ff <= bus.wdata[SPT_OUTS-1:0];
            end else if (bus.addr == ADR_EVSRC) begin
                rise_src_ff <= bus.wdata[EVS_RISE_LSB +: SPT_SRCS];
                fall_src_ff <= bus.wdata[EVS_FALL_LSB +: SPT_SRCS];
                per_src_ff <= bus.wdata[EVS_PER_LSB +: SPT_SRCS];
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            if (bus.addr == ADR_DUTY) begin
                rdata <= duty_match_value_ff;
            end else if (bus.addr == ADR_PHASE) begin
                rdata <= phase_match_value_ff;
            end else if (bus.addr == ADR_PERIOD) begin
                rdata <= period_match_value_ff;
            end else if (bus.addr == ADR_TIMER) begin
                rdata <= timebase_counter_ff;
            end else if (bus.addr == ADR_IRQ) begin
                rdata <= {8'h00, irq_en_ff, irq_flag_ff};
            end else if (bus.addr == ADR_CTRL) begin
                rdata <= {7'h00, timebase_irq_master_enable_ff, module_enable_bit_ff, 4'h0, mode_ff};
            end else if (bus.addr == ADR_CLOCK) begin
                rdata <= {10'h000, clock_divider_select_ff, 2'h0, clock_source_select_ff};
            end else if (bus.addr == ADR_BLANK) begin
                rdata <= {10'h000, fall_blank_mode_ff, 2'h0, rise_blank_mode_ff};
            end else if (bus.addr == ADR_BLKR) begin
                rdata <= {8'h00, rise_blank_time_ff};
            end else if (bus.addr == ADR_BLKF) begin
                rdata <= {8'h00, fall_blank_time_ff};
            end else if (bus.addr == ADR_REBS) begin
                rdata <= {12'h000, rise_blank_sources_ff};
            end else if (bus.addr == ADR_FEBS) begin
                rdata <= {12'h000, fall_blank_sources_ff};
            end else if (bus.addr == ADR_OEN) begin
                rdata <= {10'h000, output_enable_reg_ff};
            end else if (bus.addr == ADR_STR) begin
                rdata <= {10'h000, output_steering_reg_ff};
            end else if (bus.addr == ADR_POL) begin
                rdata <= {10'h000, output_polarity_reg_ff};
            end else if (bus.addr == ADR_EVSRC) begin
                rdata <= {4'h0, per_src_ff, fall_src_ff, rise_src_ff};
            end else if (bus.addr == ADR_MFLAG) begin
                rdata <= {15'h0000, timebase_irq_master_flag_ff};
            end else begin
                rdata <= 16'h0000;
            end
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Output stage per pin: steer, gate, then invert
    genvar gi;
    generate
        for (gi = 0; gi < SPT_OUTS; gi++) begin : g_out
            logic steer_mode;
            logic active;
            assign steer_mode = (mode_ff == MODE_SINGLE) || (mode_ff == MODE_COMPL) || (mode_ff == MODE_SIXSTEP);
            // Other modes bypass steering; waveform modes are outside this block
            assign active = pwm_ff && (!steer_mode || output_steering_reg_ff[gi]);
            always_ff @(posedge mclk) begin
                if (srst) begin
                    pwm_out[gi] <= 1'b0;
                    pwm_oe[gi] <= 1'b0;
                end else begin
                    pwm_oe[gi] <= output_enable_reg_ff[gi];
                    pwm_out[gi] <= (active && output_enable_reg_ff[gi]) ^ output_polarity_reg_ff[gi];
                end
            end
        end
    endgenerate
endmodule

// File: spt_top_sva.sv
// Port-level checker for the PWM time-base support block
`timescale 1ns/1ps
module spt_top_chk
    import spt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register bus
    input wire spt_bus_type bus,
    input wire logic [15:0] rdata,
    // Status
    input wire logic sleep_osc_keep,
    input wire logic core_tick,
    input wire logic irq_out,
    // Pins
    input wire logic [SPT_OUTS-1:0] pwm_out,
    input wire logic [SPT_OUTS-1:0] pwm_oe
);
    // Shadows of written registers
    logic [15:0] ctrl_ff;
    logic [15:0] clk_ff;
    logic [3:0] ien_ff;
    logic [5:0] oen_ff;
    logic [5:0] str_ff;
    logic [5:0] pol_ff;
    logic [3:0] age_ff; // Cycles since a config write, saturating
    logic cfg_wr;
    logic steer_mode;
    assign cfg_wr = bus.wr && (bus.addr inside {ADR_CTRL, ADR_CLOCK, ADR_OEN, ADR_STR, ADR_POL});
    assign steer_mode = ctrl_ff[2:0] inside {MODE_SINGLE, MODE_COMPL, MODE_SIXSTEP};
    // Track register writes
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_ff <= 16'h0000;
            clk_ff <= 16'h0000;
            ien_ff <= 4'h0;
            oen_ff <= 6'h00;
            str_ff <= 6'h00;
            pol_ff <= 6'h00;
        end else if (bus.wr) begin
            case (bus.addr)
                ADR_CTRL: ctrl_ff <= bus.wdata;
                ADR_CLOCK: clk_ff <= bus.wdata;
                ADR_IRQ: ien_ff <= bus.wdata[7:4];
                ADR_OEN: oen_ff <= bus.wdata[5:0];
                ADR_STR: str_ff <= bus.wdata[5:0];
                ADR_POL: pol_ff <= bus.wdata[5:0];
                default: ;
            endcase
        end
    end
    // Cycles since config write
    always_ff @(posedge mclk) begin
        if (srst || cfg_wr) begin
            age_ff <= 4'h0;
        end else if (age_ff != 4'hf) begin
            age_ff <= age_ff + 4'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_rd_unmapped;
        bus.rd && (bus.addr > ADR_MFLAG);
    endsequence
    a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
        else $error("rdata not zero");
    a_unmapped_read_zero: assert property (s_rd_unmapped |=> rdata == 16'h0000)
        else $error("unmapped read nonzero");
    a_tick_when_off: assert property (!ctrl_ff[CTRL_EN_BIT] |-> !core_tick)
        else $error("tick while off");
    a_irq_master_mask: assert property (!ctrl_ff[8] |-> !irq_out)
        else $error("irq without enable");
    a_oe_follow: assert property (age_ff > 4'h3 |-> pwm_oe == oen_ff)
        else $error("oe mismatch");
    a_idle_level: assert property (age_ff > 4'h3 && steer_mode
        |-> ((pwm_out ^ pol_ff) & oen_ff & ~str_ff) == 6'h00)
        else $error("idle level wrong");
    a_sleep_keep: assert property (sleep_osc_keep == (clk_ff[1:0] == CSRC_HFOSC))
        else $error("keep flag wrong");
    a_tick_spacing: assert property (core_tick && age_ff > 4'h3 && clk_ff[5:4] != 2'h0 |=> !core_tick)
        else $error("ticks too close");
    a_master_gate: assert property ($rose(irq_out) && $past(ctrl_ff[8])
        && !$past(bus.wr && bus.addr == ADR_MFLAG && bus.wdata[0])
        |-> ($past(ien_ff) != 4'h0 || ien_ff != 4'h0))
        else $error("master set unenabled");
endmodule
bind spt_top spt_top_chk spt_top_chk_i (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata),
    .sleep_osc_keep(sleep_osc_keep), .core_tick(core_tick), .irq_out(irq_out), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// File: spt_stage_model.sv
// Behavioural power stage and comparator event sources
`timescale 1ns/1ps
module spt_stage_model
    import spt_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Drive from the block
    input wire logic [SPT_OUTS-1:0] pwm_out,
    input wire logic [SPT_OUTS-1:0] pwm_oe,
    // Trip requests from the bench
    input wire logic [3:0] trip_req,
    // Sensed pin levels
    output logic [SPT_OUTS-1:0] pin_level,
    // Event sources
    output logic cmp1,
    output logic cmp2,
    output logic cmp3,
    output logic ext_evt
);
    logic [SPT_OUTS-1:0] last_ff; // Last pin level seen
    // A released pin floats: show a changing pattern, not a stale level
    assign pin_level = (pwm_oe & pwm_out) | (~pwm_oe & ~last_ff);
    always_ff @(posedge mclk) begin
        last_ff <= pin_level;
    end
    // Comparators come already synchronised to the system clock
    always_ff @(posedge mclk) begin
        cmp1 <= trip_req[0];
        cmp2 <= trip_req[1];
        cmp3 <= trip_req[2];
    end
    // Event pin reaches the block with no synchronisation
    assign ext_evt = trip_req[3];
endmodule

// File: test_spt_top.sv
// Self-checking bench for the PWM time-base support block
`timescale 1ns/1ps
module test_spt_top;
    import spt_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic fosc_tick = 1'b1; // Fast system clock: a tick every cycle
    logic hfosc_tick = 1'b0; // Internal oscillator silent here
    logic ext_clk_pin = 1'b0;
    logic ext_run = 1'b0; // Enables the external clock
    logic [1:0] ext_div = 2'h0;
    spt_bus_type bus_req = '0;
    logic [3:0] trip_req = 4'h0;
    logic [15:0] rdata;
    logic sleep_osc_keep, core_tick, irq_out, cmp1, cmp2, cmp3, ext_evt;
    logic [SPT_OUTS-1:0] pwm_out, pwm_oe, pin_level;
    int error_cnt = 0;
    int checks = 0;
    int cnt;
    spt_top spt_top_i (.mclk(mclk), .srst(srst), .fosc_tick(fosc_tick), .hfosc_tick(hfosc_tick),
        .ext_clk_pin(ext_clk_pin), .bus(bus_req), .rdata(rdata), .comparator1_synced_out(cmp1),
        .comparator2_synced_out(cmp2), .comparator3_synced_out(cmp3), .external_event_pin(ext_evt),
        .sleep_osc_keep(sleep_osc_keep), .core_tick(core_tick), .irq_out(irq_out), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe));
    spt_stage_model spt_stage_model_i (.mclk(mclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .trip_req(trip_req), .pin_level(pin_level), .cmp1(cmp1), .cmp2(cmp2), .cmp3(cmp3), .ext_evt(ext_evt));
    // Clock at 50 MHz
    initial begin
        forever #10 mclk = ~mclk;
    end
    // External clock source: one rising edge every four cycles
    always @(posedge mclk) begin
        ext_div <= ext_div + 2'h1;
        ext_clk_pin <= ext_run & ext_div[1];
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [4:0] a, input logic [15:0] e);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask
    // Count pin-high cycles or ticks
    task automatic count(input int n, input bit ticks);
        cnt = 0;
        repeat (n) begin
            @(posedge mclk);
            trip_req <= {4{cnt[0]}};
            #1;
            if ((ticks ? core_tick : pin_level[0]) === 1'b1) cnt++;
        end
        trip_req <= 4'h0;
    endtask
    task automatic run_pwm(input logic [15:0] duty, input logic pol, input int exp);
        wr(ADR_DUTY, duty);
        wr(ADR_POL, {15'h0, pol});
        repeat (30) @(posedge mclk);
        count(40, 1'b0);
        chk("active", exp[15:0], cnt[15:0]);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        #1 chk("oe rst", 16'h0000, {10'h0, pwm_oe});
        rd_chk("duty rst", ADR_DUTY, 16'h0000);
        wr(ADR_DUTY, 16'h1234);
        rd_chk("duty", ADR_DUTY, 16'h1234);
        rd_chk("unmapped", 5'h1f, 16'h0000);
        // Enabled, unsteered, inverted output rests high
        wr(ADR_OEN, 16'h0001);
        wr(ADR_POL, 16'h0001);
        repeat (4) @(posedge mclk);
        #1 chk("idle inv", 16'h0001, {15'h0, pwm_out[0]});
        // Period of ten core ticks, rise at count two
        wr(ADR_PERIOD, 16'h0009);
        wr(ADR_PHASE, 16'h0002);
        wr(ADR_CLOCK, 16'h0000);
        wr(ADR_STR, 16'h0001);
        wr(ADR_CTRL, 16'h0080);
        run_pwm(16'h0002, 1'b0, 0);
        run_pwm(16'h0006, 1'b0, 16);
        run_pwm(16'h0020, 1'b0, 40);
        run_pwm(16'h0002, 1'b1, 40);
        // Prescaler settings on the system clock source
        for (int d = 0; d < 4; d++) begin
            wr(ADR_CLOCK, 16'(d << CLK_DIV_LSB));
            repeat (4) @(posedge mclk);
            count(64, 1'b1);
            chk("div ticks", 16'(64 >> d), cnt[15:0]);
        end
        wr(ADR_CLOCK, {14'h0, CSRC_HFOSC});
        count(64, 1'b1);
        chk("hf ticks", 16'h0000, cnt[15:0]);
        chk("sleep keep", 16'h0001, {15'h0, sleep_osc_keep});
        wr(ADR_CLOCK, {14'h0, CSRC_EXT});
        ext_run <= 1'b1;
        repeat (8) @(posedge mclk);
        count(64, 1'b1);
        chk("ext ticks", 16'h0010, cnt[15:0]);
        ext_run <= 1'b0;
        wr(ADR_CLOCK, {14'h0, CSRC_FOSC});
        // Interrupt flags, master flag and clearing order
        wr(ADR_DUTY, 16'h0006);
        wr(ADR_IRQ, 16'h0000);
        wr(ADR_MFLAG, 16'h0000);
        repeat (25) @(posedge mclk);
        rd_chk("flags", ADR_IRQ, 16'h000e);
        rd_chk("mflag off", ADR_MFLAG, 16'h0000);
        wr(ADR_IRQ, 16'h0080);
        repeat (25) @(posedge mclk);
        rd_chk("mflag on", ADR_MFLAG, 16'h0001);
        wr(ADR_CTRL, 16'h0180);
        #1 chk("irq line", 16'h0001, {15'h0, irq_out});
        wr(ADR_CTRL, 16'h0100);
        rd_chk("flags dis", ADR_IRQ, 16'h0080);
        rd_chk("mflag dis", ADR_MFLAG, 16'h0001);
        wr(ADR_MFLAG, 16'h0000);
        rd_chk("mflag clr", ADR_MFLAG, 16'h0000);
        chk("irq clr", 16'h0000, {15'h0, irq_out});
        wr(ADR_CTRL, 16'h0180);
        wr(ADR_IRQ, 16'h0011);
        repeat (3) @(posedge mclk);
        #1 chk("sw irq", 16'h0001, {15'h0, irq_out});
        print_verdict;
    end
endmodule
